// ===== bench/oc_load_model.sv
/*
  Model of the over-current detectors standing at the high-current pins.
  Assumes fault requests from the bench, synchronous to core_clk_in.
*/
`timescale 1ns/1ps
module oc_load_model (
  input wire logic core_clk_in,
  input wire logic [7:0] fault_in,
  input wire logic [7:0] detector_en_in,
  output logic [7:0] oc_detect_out
);
  always_ff @(posedge core_clk_in) begin
    oc_detect_out <= fault_in & detector_en_in;
  end
endmodule // oc_load_model

// ===== bench/port_pin_config_overcurrent_test.sv
/*
  Self-checking bench for the pin configuration and over-current slice.
  Assumes an APB slave; every wait for its answer is bounded.
*/
`timescale 1ns/1ps
module port_pin_config_overcurrent_test;
  import pin_cfg_pkg::*;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [ADDR_W-1:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd;
  logic [3:0] pstrb_in = 4'h0;
  logic [3:0] strb = 4'h1;
  logic pready_out, pslverr_out, oc_irq_out, err;
  logic [15:0] periph_digital_use_in = 16'h0000, input_buffer_en_out;
  logic [7:0] port_s_output_mode_in = 8'h00, port_j_output_mode_in = 8'h00, drive_output_mode_in = 8'h00;
  logic [7:0] fault = 8'h00, oc_detect_in, port_s_high_side_en_out, port_s_low_side_en_out;
  logic [7:0] port_j_high_side_en_out, port_j_low_side_en_out, reduced_drive_out, oc_detector_en_out;
  int error_cnt = 0, comparisons = 0;
  always #20 core_clk_in = ~core_clk_in;
  port_pin_config_overcurrent dut_u (.core_clk_in(core_clk_in), .srst_in(srst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in), .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .periph_digital_use_in(periph_digital_use_in), .port_s_output_mode_in(port_s_output_mode_in),
    .port_j_output_mode_in(port_j_output_mode_in), .drive_output_mode_in(drive_output_mode_in),
    .oc_detect_in(oc_detect_in), .input_buffer_en_out(input_buffer_en_out),
    .port_s_high_side_en_out(port_s_high_side_en_out), .port_s_low_side_en_out(port_s_low_side_en_out),
    .port_j_high_side_en_out(port_j_high_side_en_out), .port_j_low_side_en_out(port_j_low_side_en_out),
    .reduced_drive_out(reduced_drive_out), .oc_detector_en_out(oc_detector_en_out), .oc_irq_out(oc_irq_out));
  oc_load_model model_u (.core_clk_in(core_clk_in), .fault_in(fault), .detector_en_in(oc_detector_en_out),
    .oc_detect_out(oc_detect_in));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
    int n;
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= {idx, 2'b00};
    pwdata_in <= {24'h000000, wd};
    pstrb_in <= strb;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (pready_out !== 1'b1) begin
      chk("pready", pready_out, 1'b1);
      test_done();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rdchk(input string name, input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(name, rd, {24'h000000, exp});
  endtask
  task automatic settle();
    repeat (3) @(negedge core_clk_in);
    @(posedge core_clk_in);
  endtask
  task automatic test_reset();
    logic [IDX_W-1:0] regs [9];
    regs = '{IDX_DIEN_HIGH, IDX_DIEN_LOW, IDX_OD_PORT_S, IDX_OD_PORT_J, IDX_DRIVE, IDX_RSVD,
      IDX_OC_DET_EN, IDX_OC_IRQ_EN, IDX_OC_FLAGS};
    foreach (regs[i]) begin
      rdchk("reset value", regs[i], 8'h00);
    end
    $display("test reset done");
  endtask
  task automatic test_input_buffer();
    apb(1'b1, IDX_DIEN_HIGH, 8'hA5);
    apb(1'b1, IDX_DIEN_LOW, 8'h3C);
    periph_digital_use_in <= 16'h4201;
    settle();
    chk("input buffer", input_buffer_en_out, 16'hA53C | 16'h4201);
    apb(1'b1, IDX_DIEN_LOW, 8'h38);
    periph_digital_use_in <= 16'h0000;
    settle();
    chk("input buffer", input_buffer_en_out, 16'hA538);
    rdchk("dien low", IDX_DIEN_LOW, 8'h38);
    $display("test input buffer done");
  endtask
  task automatic test_drive_open_drain();
    apb(1'b1, IDX_DRIVE, 8'hF0);
    apb(1'b1, IDX_OD_PORT_S, 8'h0F);
    apb(1'b1, IDX_OD_PORT_J, 8'hF0);
    drive_output_mode_in <= 8'h3C;
    port_s_output_mode_in <= 8'hFF;
    port_j_output_mode_in <= 8'h55;
    settle();
    chk("reduced drive", reduced_drive_out, 8'h30);
    chk("s high", port_s_high_side_en_out, 8'hF0);
    chk("s low", port_s_low_side_en_out, 8'hFF);
    chk("j high", port_j_high_side_en_out, 8'h05);
    chk("j low", port_j_low_side_en_out, 8'h55);
    rdchk("drive reg", IDX_DRIVE, 8'hF0);
    rdchk("open drain j", IDX_OD_PORT_J, 8'hF0);
    $display("test drive and open drain done");
  endtask
  task automatic test_reserved();
    apb(1'b1, IDX_RSVD, 8'hFF);
    rdchk("reserved", IDX_RSVD, RSVD_VALUE);
    chk("reserved err", err, 1'b0);
    apb(1'b0, 10'h000, 8'h00);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h00000000);
    strb = 4'h0;
    apb(1'b1, IDX_DRIVE, 8'h0F);
    strb = 4'h1;
    rdchk("strobe off write", IDX_DRIVE, 8'hF0);
    $display("test reserved done");
  endtask
  task automatic test_overcurrent();
    apb(1'b1, IDX_OC_DET_EN, 8'hFF);
    apb(1'b1, IDX_OC_IRQ_EN, 8'h04);
    fault <= 8'hFF;
    settle();
    chk("detector en", oc_detector_en_out, OC_MASK);
    fault <= 8'h00;
    rdchk("detector reg", IDX_OC_DET_EN, OC_MASK);
    rdchk("flags", IDX_OC_FLAGS, 8'h75);
    chk("irq", oc_irq_out, 1'b1);
    apb(1'b1, IDX_OC_FLAGS, 8'h70);
    rdchk("flags kept", IDX_OC_FLAGS, 8'h05);
    chk("irq", oc_irq_out, 1'b1);
    apb(1'b1, IDX_OC_IRQ_EN, 8'h10);
    settle();
    chk("irq masked", oc_irq_out, 1'b0);
    apb(1'b1, IDX_OC_FLAGS, 8'h05);
    rdchk("flags clear", IDX_OC_FLAGS, 8'h00);
    $display("test overcurrent done");
  endtask
  initial begin
    repeat (8) @(posedge core_clk_in);
    srst_in <= 1'b0;
    test_reset();
    test_input_buffer();
    test_drive_open_drain();
    test_reserved();
    test_overcurrent();
    test_done();
  end
endmodule // port_pin_config_overcurrent_test

// ===== design/pin_cfg_pkg.sv
/*
  Constants for the pin configuration and over-current register slice.
  Assumes a 32-bit APB master and one 25 MHz clock with a synchronous reset.
*/
package pin_cfg_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_DIEN_HIGH = 10'h298;
  localparam logic [IDX_W-1:0] IDX_DIEN_LOW = 10'h299;
  localparam logic [IDX_W-1:0] IDX_OD_PORT_S = 10'h2DF;
  localparam logic [IDX_W-1:0] IDX_OD_PORT_J = 10'h31F;
  localparam logic [IDX_W-1:0] IDX_DRIVE = 10'h2A8;
  localparam logic [IDX_W-1:0] IDX_RSVD = 10'h2A9;
  localparam logic [IDX_W-1:0] IDX_OC_DET_EN = 10'h2AA;
  localparam logic [IDX_W-1:0] IDX_OC_IRQ_EN = 10'h2AB;
  localparam logic [IDX_W-1:0] IDX_OC_FLAGS = 10'h2AC;
  // Reset values.
  localparam logic [DATA_W-1:0] RST_DIEN = 8'h00;
  localparam logic [DATA_W-1:0] RST_OD = 8'h00;
  localparam logic [DATA_W-1:0] RST_DRIVE = 8'h00;
  localparam logic [DATA_W-1:0] RST_OC = 8'h00;
  localparam logic [DATA_W-1:0] RSVD_VALUE = 8'h00;
  // Over-current bit positions.
  localparam int OC_PIN6 = 6;
  localparam int OC_PIN5 = 5;
  localparam int OC_PIN4 = 4;
  localparam int OC_SUPPLY = 2;
  localparam int OC_PIN0 = 0;
  localparam logic [DATA_W-1:0] OC_MASK = 8'h75;
  // Reduced drive is about one tenth of full strength.
  localparam int DRIVE_RATIO_DEN = 10;
endpackage

// ===== design/port_pin_config_overcurrent.sv
/*
  APB register slice holding per-pin input buffer, drive strength and open-drain
  controls, plus over-current enables, interrupt enables and flags.
  Assumes inputs synchronous to core_clk_in; detectors and pads sit outside.
*/
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - Input buffer enable bit 1 turns the pin's digital input buffer on.
// - A peripheral using the pin digitally forces its input buffer on.
// - Unimplemented bit positions always read zero.
// - Drive strength bit 1 selects reduced drive, 0 full drive.
// - Drive setting applies to any output function, not to inputs.
// - Open-drain bit 1 disables high-side drive; 0 means push-pull.
// - Open-drain bits do not affect input pins.
// - Reserved register reads zero and ignores writes.
// - Detector enables at bits 6,5,4,0 for pins, bit 2 for supply.
// - Interrupt enable bit allows, clear bit masks, its flag.
// - Detected over-current sets the flag at the enable's position.
// - Writing 1 clears a flag unless a detection sets it in the same cycle; flags are readable anytime.
// - Configuration registers accept reads and writes at any time.
module port_pin_config_overcurrent
  import pin_cfg_pkg::*;
#(
  parameter logic [DATA_W-1:0] DIEN_HIGH_MASK = 8'hFF,
  parameter logic [DATA_W-1:0] DIEN_LOW_MASK = 8'hFF,
  parameter logic [DATA_W-1:0] OD_S_MASK = 8'hFF,
  parameter logic [DATA_W-1:0] OD_J_MASK = 8'hFF,
  parameter logic [DATA_W-1:0] DRIVE_MASK = 8'hFF
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  input wire logic [15:0] periph_digital_use_in,
  input wire logic [7:0] port_s_output_mode_in,
  input wire logic [7:0] port_j_output_mode_in,
  input wire logic [7:0] drive_output_mode_in,
  input wire logic [7:0] oc_detect_in,
  output logic [15:0] input_buffer_en_out,
  output logic [7:0] port_s_high_side_en_out,
  output logic [7:0] port_s_low_side_en_out,
  output logic [7:0] port_j_high_side_en_out,
  output logic [7:0] port_j_low_side_en_out,
  output logic [7:0] reduced_drive_out,
  output logic [7:0] oc_detector_en_out,
  output logic oc_irq_out
);

  logic [DATA_W-1:0] dien_high_ff;
  logic [DATA_W-1:0] dien_low_ff;
  logic [DATA_W-1:0] od_s_ff;
  logic [DATA_W-1:0] od_j_ff;
  logic [DATA_W-1:0] drive_ff;
  logic [DATA_W-1:0] oc_det_en_ff;
  logic [DATA_W-1:0] oc_irq_en_ff;
  logic [DATA_W-1:0] oc_flags_ff;
  logic [DATA_W-1:0] nxt_oc_flags;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [IDX_W-1:0] idx;
  logic setup;
  logic access;
  logic wr_en;
  logic hit;
  logic [15:0] dien_all;

  assign idx = paddr_in[ADDR_W-1:2];
  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in & pready_out;
  assign wr_en = access & pwrite_in & pstrb_in[0];
  assign wdata = pwdata_in[DATA_W-1:0];
  assign dien_all = {dien_high_ff, dien_low_ff};

  // Address decode and read mux.
  always_comb begin
    hit = 1'b1;
    rdata = 8'h00;
    if (idx == IDX_DIEN_HIGH) begin
      rdata = dien_high_ff & DIEN_HIGH_MASK;
    end else if (idx == IDX_DIEN_LOW) begin
      rdata = dien_low_ff & DIEN_LOW_MASK;
    end else if (idx == IDX_OD_PORT_S) begin
      rdata = od_s_ff & OD_S_MASK;
    end else if (idx == IDX_OD_PORT_J) begin
      rdata = od_j_ff & OD_J_MASK;
    end else if (idx == IDX_DRIVE) begin
      rdata = drive_ff & DRIVE_MASK;
    end else if (idx == IDX_RSVD) begin
      rdata = RSVD_VALUE;
    end else if (idx == IDX_OC_DET_EN) begin
      rdata = oc_det_en_ff & OC_MASK;
    end else if (idx == IDX_OC_IRQ_EN) begin
      rdata = oc_irq_en_ff & OC_MASK;
    end else if (idx == IDX_OC_FLAGS) begin
      rdata = oc_flags_ff & OC_MASK;
    end else begin
      hit = 1'b0;
    end
  end

  // APB answer: one wait-free access phase after every setup.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= setup;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, rdata};
      pslverr_out <= ~hit;
    end else begin
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      dien_high_ff <= RST_DIEN;
      dien_low_ff <= RST_DIEN;
      od_s_ff <= RST_OD;
      od_j_ff <= RST_OD;
      drive_ff <= RST_DRIVE;
      oc_det_en_ff <= RST_OC;
      oc_irq_en_ff <= RST_OC;
    end else if (wr_en) begin
      if (idx == IDX_DIEN_HIGH) begin
        dien_high_ff <= wdata & DIEN_HIGH_MASK;
      end else if (idx == IDX_DIEN_LOW) begin
        dien_low_ff <= wdata & DIEN_LOW_MASK;
      end else if (idx == IDX_OD_PORT_S) begin
        od_s_ff <= wdata & OD_S_MASK;
      end else if (idx == IDX_OD_PORT_J) begin
        od_j_ff <= wdata & OD_J_MASK;
      end else if (idx == IDX_DRIVE) begin
        drive_ff <= wdata & DRIVE_MASK;
      end else if (idx == IDX_OC_DET_EN) begin
        oc_det_en_ff <= wdata & OC_MASK;
      end else if (idx == IDX_OC_IRQ_EN) begin
        oc_irq_en_ff <= wdata & OC_MASK;
      end
    end
  end

  // Over-current flags, one per implemented position.
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_flag
      logic set_bit;
      logic clr_bit;
      assign set_bit = OC_MASK[gi] & oc_det_en_ff[gi] & oc_detect_in[gi];
      assign clr_bit = wr_en & (idx == IDX_OC_FLAGS) & wdata[gi];
      assign nxt_oc_flags[gi] = set_bit | (oc_flags_ff[gi] & ~clr_bit);
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      oc_flags_ff <= RST_OC;
    end else begin
      oc_flags_ff <= nxt_oc_flags;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      input_buffer_en_out <= 16'h0000;
    end else begin
      input_buffer_en_out <= dien_all | periph_digital_use_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      port_s_high_side_en_out <= 8'h00;
      port_s_low_side_en_out <= 8'h00;
      port_j_high_side_en_out <= 8'h00;
      port_j_low_side_en_out <= 8'h00;
    end else begin
      port_s_high_side_en_out <= port_s_output_mode_in & ~od_s_ff;
      port_s_low_side_en_out <= port_s_output_mode_in;
      port_j_high_side_en_out <= port_j_output_mode_in & ~od_j_ff;
      port_j_low_side_en_out <= port_j_output_mode_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      reduced_drive_out <= 8'h00;
    end else begin
      reduced_drive_out <= drive_output_mode_in & drive_ff;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      oc_detector_en_out <= 8'h00;
      oc_irq_out <= 1'b0;
    end else begin
      oc_detector_en_out <= oc_det_en_ff & OC_MASK;
      oc_irq_out <= |(nxt_oc_flags & oc_irq_en_ff);
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_access;
    psel_in && penable_in && pready_out;
  endsequence

  AST_READY: assert property (s_setup |=> pready_out)
    else $error("Setup not answered in next cycle.");
  AST_RSVD_READ: assert property ((s_setup and (idx == IDX_RSVD) && !pwrite_in) |=>
    (prdata_out == 32'h0000_0000))
    else $error("Reserved register read nonzero.");
  AST_RSVD_WRITE: assert property ((s_setup and (idx == IDX_RSVD)) ##1 s_access |=>
    $stable(oc_irq_en_ff) && $stable(drive_ff))
    else $error("Reserved write changed state.");
  AST_UNIMPL_ZERO: assert property (s_setup |=> ((prdata_out & ~{24'h00_0000, OC_MASK}) == 32'h0000_0000) ||
    ($past(idx) != IDX_OC_FLAGS))
    else $error("Unimplemented flag bits read nonzero.");
  AST_BUF_FORCE: assert property (1 |=> ((input_buffer_en_out & $past(periph_digital_use_in))
    == $past(periph_digital_use_in)))
    else $error("Peripheral use did not force buffer on.");
  AST_BUF_EN: assert property (1 |=> (input_buffer_en_out == ($past(dien_all) |
    $past(periph_digital_use_in))))
    else $error("Input buffer enable mismatch.");
  AST_DRIVE_INPUT: assert property (1 |=> ((reduced_drive_out & ~$past(drive_output_mode_in))
    == 8'h00))
    else $error("Reduced drive active on input pin.");
  AST_OPEN_DRAIN: assert property (1 |=> ((port_s_high_side_en_out & $past(od_s_ff)) == 8'h00)
    && (port_s_low_side_en_out == $past(port_s_output_mode_in)))
    else $error("Open-drain pin drove high.");
  AST_FLAG_SET: assert property ((oc_det_en_ff[OC_PIN6] && oc_detect_in[OC_PIN6]) |=>
    oc_flags_ff[OC_PIN6] ##1 (oc_flags_ff[OC_PIN6] || $past(wr_en)))
    else $error("Over-current flag not set.");
  AST_FLAG_CLEAR: assert property ((s_access and (pwrite_in && idx == IDX_OC_FLAGS &&
    pwdata_in[OC_SUPPLY] && pstrb_in[0] && !oc_detect_in[OC_SUPPLY])) |=>
    !oc_flags_ff[OC_SUPPLY])
    else $error("Write one did not clear flag.");
  AST_FLAG_KEEP: assert property ((oc_flags_ff[OC_PIN0] && !(wr_en && idx == IDX_OC_FLAGS &&
    wdata[OC_PIN0])) |=> oc_flags_ff[OC_PIN0])
    else $error("Flag lost without write one.");
  AST_IRQ: assert property (oc_irq_out == |(oc_flags_ff & $past(oc_irq_en_ff)))
    else $error("Interrupt request mismatch.");
  AST_RSVD_NO_ERR: assert property ((s_setup and (idx == IDX_RSVD)) |=>
    !pslverr_out)
    else $error("Reserved register access flagged an error.");
  AST_UNMAPPED_ERR: assert property ((s_setup and !hit) |=>
    (pslverr_out && (prdata_out == 32'h0000_0000)))
    else $error("Unmapped access not refused.");
  AST_DET_MASK: assert property ((oc_detector_en_out & ~OC_MASK) ==
    8'h00)
    else $error("Detector enabled outside monitored pins.");
  AST_DRIVE_SEL: assert property (1 |=> (reduced_drive_out ==
    ($past(drive_output_mode_in) & $past(drive_ff))))
    else $error("Reduced drive selection mismatch.");
  AST_PUSH_PULL: assert property (1 |=> (port_s_high_side_en_out ==
    ($past(port_s_output_mode_in) & ~$past(od_s_ff))))
    else $error("Push-pull pin lost high-side drive.");
  AST_INPUT_PINS: assert property (1 |=> (((port_j_high_side_en_out | port_j_low_side_en_out) &
    ~$past(port_j_output_mode_in)) == 8'h00))
    else $error("Input pin drove its output.");
  AST_FLAG_READ: assert property ((s_setup and (idx == IDX_OC_FLAGS) && !pwrite_in) |=>
    (prdata_out == {24'h00_0000, $past(oc_flags_ff)}))
    else $error("Flag readback mismatch.");
  AST_FLAG_QUIET: assert property ((!oc_flags_ff[OC_PIN4] && !oc_detect_in[OC_PIN4]) |=>
    !oc_flags_ff[OC_PIN4])
    else $error("Flag set without a detected event.");

endmodule // port_pin_config_overcurrent
